// >>> shared/rsc_pkg.sv
// Package: constants and types of the call, return and stack unit
package rsc_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int PC_W = 21;
  localparam int STK_DEPTH = 31;
  localparam int STK_PTR_W = 5;
  localparam int DATA_W = 8;
  localparam int OP_W = 16;
  localparam int AV_AW = 8;
  localparam int AV_DW = 32;
  localparam int AV_BE_W = 4;

  // ************************************************************
  // Opcodes and opcode fields
  // ************************************************************
  localparam logic [OP_W-1:0] OP_IDLE = 16'h0000;
  localparam logic [OP_W-1:0] OP_PUSH = 16'h0005;
  localparam logic [OP_W-1:0] OP_DISCARD = 16'h0006;
  localparam logic [OP_W-1:0] OP_SWRST = 16'h00ff;
  localparam logic [4:0] OP_RELATIVE_SUBROUTINE_CALL_PFX = 5'h1b;
  localparam logic [14:0] OP_INTERRUPT_RETURN_PFX = 15'h0008;
  localparam logic [14:0] OP_RETURN_PFX = 15'h0009;
  localparam logic [7:0] OP_RETURN_WITH_LITERAL_PFX = 8'h0c;
  localparam logic [3:0] OP_NOP2_PFX = 4'hf;
  localparam int OP_S_BIT = 0;
  localparam int OP_OFS_MSB = 10;
  localparam int OP_LIT_MSB = 7;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // ************************************************************
  // Register offsets (byte addresses) and fields
  // ************************************************************
  localparam logic [AV_AW-1:0] REG_INSTR = 8'h00;
  localparam logic [AV_AW-1:0] REG_PC = 8'h04;
  localparam logic [AV_AW-1:0] REG_ACC = 8'h08;
  localparam logic [AV_AW-1:0] REG_STATUS = 8'h0c;
  localparam logic [AV_AW-1:0] REG_BANK = 8'h10;
  localparam logic [AV_AW-1:0] REG_SH_ACC = 8'h14;
  localparam logic [AV_AW-1:0] REG_SH_STATUS = 8'h18;
  localparam logic [AV_AW-1:0] REG_SH_BANK = 8'h1c;
  localparam logic [AV_AW-1:0] REG_IRQ_EN = 8'h20;
  localparam logic [AV_AW-1:0] REG_PC_HIGH = 8'h24;
  localparam logic [AV_AW-1:0] REG_PC_UPPER = 8'h28;
  localparam logic [AV_AW-1:0] REG_STK_TOP = 8'h2c;
  localparam logic [AV_AW-1:0] REG_STK_STAT = 8'h30;
  localparam int IRQ_HI_BIT = 0;
  localparam int IRQ_LO_BIT = 1;
  localparam int STK_FULL_BIT = 6;
  localparam int STK_UNF_BIT = 7;
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [PC_W-1:0] RST_PC = 21'h000000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } rsc_phase_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b10
  } rsc_state_t;

  typedef struct packed {
    logic [AV_AW-1:0] address;
    logic read;
    logic write;
    logic [AV_DW-1:0] writedata;
    logic [AV_BE_W-1:0] byteenable;
  } rsc_av_req_t;

endpackage : rsc_pkg

// >>> tb/tb.sv
// Self-checking bench for the call, return and stack instruction unit
`timescale 1ns/1ps
module tb
  import rsc_pkg::*;
;
  // ************************************************************
  // Clock, reset and bus signals
  // ************************************************************
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  rsc_av_req_t req = '0;
  logic [AV_DW-1:0] rdata;
  logic wait_req;
  int n_errors = 0;
  int n_checks = 0;
  logic [20:0] exp_pc;
  int ofs [4] = '{-1024, -1, 0, 1023};

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  rsc_call_ret_unit uut (
    .REF_CLK_I(ref_clk),
    .RST_I(rst),
    .CE_I(ce),
    .AVS_REQ_I(req),
    .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_req)
  );

  // ************************************************************
  // Bus tasks and comparison
  // ************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Holds the request until waitrequest is sampled low at a rising edge
  task automatic av_access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] q);
    int k;
    @(posedge ref_clk);
    req.address <= a;
    req.read <= ~wr;
    req.write <= wr;
    req.writedata <= d;
    req.byteenable <= 4'hf;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wait_req !== 1'b0 && k < 100);
    q = rdata;
    if (k >= 100) begin
      n_errors++;
      $display("[ERR] bus answer expected waitrequest low seen none");
    end
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : av_access

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    av_access(1'b1, a, d, q);
  endtask : wr

  task automatic exec(input logic [15:0] op);
    wr(REG_INSTR, {16'h0000, op});
  endtask : exec

  // Reads a register and compares it with the expected word
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    av_access(1'b0, a, 32'h00000000, q);
    check($sformatf("reg 0x%h", a), q, exp);
  endtask : rd_chk

  // ************************************************************
  // Watchdog: whole run needs well under 3000 cycles
  // ************************************************************
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("[ERR] run expected end seen timeout");
    tally_and_finish();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(REG_PC, 32'h0);
    rd_chk(REG_STK_STAT, 32'h0);
    rd_chk(8'h40, 32'h0);
    // Push stacks PC plus 2 and steps PC
    wr(REG_PC, 32'h124);
    exec(OP_PUSH);
    rd_chk(REG_PC, 32'h126);
    rd_chk(REG_STK_TOP, 32'h126);
    exec(OP_PUSH);
    rd_chk(REG_STK_TOP, 32'h128);
    // Discard exposes the entry below
    exec(OP_DISCARD);
    rd_chk(REG_STK_TOP, 32'h126);
    rd_chk(REG_STK_STAT, 32'h1);
    rd_chk(REG_PC, 32'h12a);
    // Relative call at both offset limits and in between
    for (int i = 0; i < 4; i++) begin
      wr(REG_PC, 32'h1000);
      exec({OP_RELATIVE_SUBROUTINE_CALL_PFX, ofs[i][10:0]});
      exp_pc = 21'h001002 + 21'(ofs[i] * 2);
      rd_chk(REG_STK_TOP, 32'h1002);
      rd_chk(REG_PC, {11'h0, exp_pc});
    end
    rd_chk(REG_STK_STAT, 32'h5);
    // Literal return keeps the latches
    wr(REG_PC_HIGH, 32'h5a);
    wr(REG_PC_UPPER, 32'h13);
    exec(16'h0ca5);
    rd_chk(REG_ACC, 32'ha5);
    rd_chk(REG_PC, 32'h1002);
    rd_chk(REG_PC_HIGH, 32'h5a);
    // Subroutine return without and with shadow restore
    wr(REG_SH_ACC, 32'h11);
    wr(REG_SH_STATUS, 32'h12);
    wr(REG_SH_BANK, 32'h03);
    exec({OP_RETURN_PFX, 1'b0});
    rd_chk(REG_ACC, 32'ha5);
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_PC, 32'h1002);
    exec({OP_RETURN_PFX, 1'b1});
    rd_chk(REG_ACC, 32'h11);
    rd_chk(REG_STATUS, 32'h12);
    rd_chk(REG_BANK, 32'h03);
    rd_chk(REG_STK_STAT, 32'h2);
    // Interrupt return: enables, pop, latches untouched
    wr(REG_ACC, 32'h77);
    exec({OP_INTERRUPT_RETURN_PFX, 1'b0});
    rd_chk(REG_IRQ_EN, 32'h1);
    rd_chk(REG_PC, 32'h1002);
    rd_chk(REG_ACC, 32'h77);
    rd_chk(REG_PC_HIGH, 32'h5a);
    rd_chk(REG_PC_UPPER, 32'h13);
    exec({OP_INTERRUPT_RETURN_PFX, 1'b1});
    rd_chk(REG_IRQ_EN, 32'h3);
    rd_chk(REG_PC, 32'h126);
    rd_chk(REG_ACC, 32'h11);
    rd_chk(REG_STK_STAT, 32'h0);
    // Idle words, including a second-word pattern
    exec(OP_IDLE);
    rd_chk(REG_PC, 32'h128);
    exec(16'hf123);
    rd_chk(REG_PC, 32'h12a);
    rd_chk(REG_STK_STAT, 32'h0);
    rd_chk(REG_ACC, 32'h11);
    // Clock enable low in mid-instruction freezes the phases, then resumes
    fork
      exec(OP_IDLE);
      begin
        repeat (3) @(posedge ref_clk);
        ce <= 1'b0;
        repeat (4) @(posedge ref_clk);
        ce <= 1'b1;
      end
    join
    rd_chk(REG_PC, 32'h12c);
    rd_chk(REG_STK_STAT, 32'h0);
    // Software reset clears the registers and the stack pointer; the sequencer and opcode latch keep theirs
    exec(OP_PUSH);
    exec(OP_SWRST);
    rd_chk(REG_PC, 32'h0);
    rd_chk(REG_ACC, 32'h0);
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_BANK, 32'h0);
    rd_chk(REG_IRQ_EN, 32'h0);
    rd_chk(REG_SH_ACC, 32'h0);
    rd_chk(REG_PC_HIGH, 32'h0);
    rd_chk(REG_STK_STAT, 32'h0);
    tally_and_finish();
  end
endmodule : tb

// >>> verilog/rsc_call_ret_unit.sv
// Call, return and stack instruction unit behind an Avalon-MM slave
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module rsc_call_ret_unit
  import rsc_pkg::*;
#(
  parameter int DEPTH = STK_DEPTH
)
(
  // Clock, reset and enable
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // Avalon-MM slave
  input wire rsc_av_req_t AVS_REQ_I,
  output logic [AV_DW-1:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O
);

  // ************************************************************
  // Declarations
  // ************************************************************
  rsc_state_t state_reg;
  rsc_state_t state_next;
  rsc_phase_t phase_reg;
  rsc_phase_t phase_next;
  logic cyc_reg;
  logic cyc_next;
  logic [OP_W-1:0] op_reg;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [DATA_W-1:0] acc_reg;
  logic [DATA_W-1:0] stat_reg;
  logic [DATA_W-1:0] bank_reg;
  logic [DATA_W-1:0] sh_acc_reg;
  logic [DATA_W-1:0] sh_stat_reg;
  logic [DATA_W-1:0] sh_bank_reg;
  logic [DATA_W-1:0] pc_high_reg;
  logic [DATA_W-1:0] pc_upper_reg;
  logic irq_hi_reg;
  logic irq_lo_reg;
  logic [AV_DW-1:0] rdata_reg;
  logic [PC_W-1:0] stk_top;
  logic [STK_PTR_W-1:0] stk_depth;
  logic stk_full;
  logic stk_unf;

  // Byte-lane merge of a write into an old register value
  function automatic logic [AV_DW-1:0] lane_merge(
    input logic [AV_DW-1:0] old_val,
    input logic [AV_DW-1:0] new_val,
    input logic [AV_BE_W-1:0] be
  );
    logic [AV_DW-1:0] res;
    res = old_val;
    for (int i = 0; i < AV_BE_W; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire av_req = AVS_REQ_I.read || AVS_REQ_I.write;
  wire [AV_AW-1:0] av_addr = AVS_REQ_I.address;
  wire [AV_DW-1:0] av_wd = AVS_REQ_I.writedata;
  wire [AV_BE_W-1:0] av_be = AVS_REQ_I.byteenable;
  wire hit_instr = av_addr == REG_INSTR;
  wire hit_pc = av_addr == REG_PC;
  wire hit_acc = av_addr == REG_ACC;
  wire hit_stat = av_addr == REG_STATUS;
  wire hit_bank = av_addr == REG_BANK;
  wire hit_sacc = av_addr == REG_SH_ACC;
  wire hit_sstat = av_addr == REG_SH_STATUS;
  wire hit_sbank = av_addr == REG_SH_BANK;
  wire hit_irq = av_addr == REG_IRQ_EN;
  wire hit_pch = av_addr == REG_PC_HIGH;
  wire hit_pcu = av_addr == REG_PC_UPPER;
  wire hit_stop = av_addr == REG_STK_TOP;
  wire hit_sst = av_addr == REG_STK_STAT;

  // Answer in the done state; a frozen clock enable delays the answer and keeps waitrequest high
  wire done_ce = CE_I && state_reg == ST_DONE;
  wire bus_wr = done_ce && AVS_REQ_I.write;
  wire start_exec = state_reg == ST_IDLE && AVS_REQ_I.write && hit_instr;
  assign AVS_WAITREQUEST_O = av_req && !done_ce;

  // ************************************************************
  // Instruction decode
  // ************************************************************
  wire is_push = op_reg == OP_PUSH;
  wire is_discard = op_reg == OP_DISCARD;
  wire is_swrst = op_reg == OP_SWRST;
  wire is_relative_subroutine_call = op_reg[15:11] == OP_RELATIVE_SUBROUTINE_CALL_PFX;
  wire is_interrupt_return = op_reg[15:1] == OP_INTERRUPT_RETURN_PFX;
  wire is_return = op_reg[15:1] == OP_RETURN_PFX;
  wire is_return_with_literal = op_reg[15:8] == OP_RETURN_WITH_LITERAL_PFX;
  wire is_ret = is_interrupt_return || is_return || is_return_with_literal;
  wire two_cyc = is_relative_subroutine_call || is_ret;
  wire shadow_sel = (is_interrupt_return || is_return) && op_reg[OP_S_BIT];
  // Words with the second-word prefix decode as idle on purpose
  wire is_nop2 = op_reg[15:12] == OP_NOP2_PFX;
  wire is_idle = op_reg == OP_IDLE || is_nop2;

  // ************************************************************
  // Phase sequencer: four phases per cycle, one or two cycles
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    cyc_next = cyc_reg;
    unique case (state_reg)
      ST_IDLE: begin
        phase_next = PH_Q1;
        cyc_next = 1'b0;
        if (av_req) begin
          state_next = start_exec ? ST_RUN : ST_DONE;
        end
      end
      ST_RUN: begin
        phase_next = rsc_phase_t'(phase_reg + 2'b01);
        if (phase_reg == PH_Q4) begin
          if (two_cyc && !cyc_reg) begin
            cyc_next = 1'b1;
          end else begin
            state_next = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer survives a software reset so the bus still gets its answer
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_Q1;
      cyc_reg <= 1'b0;
    end else if (CE_I) begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cyc_reg <= cyc_next;
    end
  end

  // Opcode latch
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      op_reg <= OP_IDLE;
    end else if (CE_I && start_exec) begin
      op_reg <= av_wd[OP_W-1:0];
    end
  end

  // ************************************************************
  // Execution strobes; the second cycle does nothing
  // ************************************************************
  wire run_ce = CE_I && state_reg == ST_RUN && !cyc_reg;
  wire do_swrst = run_ce && phase_reg == PH_Q1 && is_swrst;
  wire do_push = run_ce && phase_reg == PH_Q2 && (is_push || is_relative_subroutine_call);
  wire pop_q3 = phase_reg == PH_Q3 && is_discard;
  wire pop_q4 = phase_reg == PH_Q4 && is_ret;
  wire do_pop = run_ce && (pop_q3 || pop_q4);
  wire do_q4 = run_ce && phase_reg == PH_Q4;
  wire arch_rst = RST_I || do_swrst;

  // ************************************************************
  // Program counter
  // ************************************************************
  wire [PC_W-1:0] pc_inc = pc_reg + PC_STEP;
  wire [PC_W-1:0] rel_ofs = {{(PC_W-12){op_reg[OP_OFS_MSB]}}, op_reg[10:0], 1'b0};
  wire [PC_W-1:0] call_tgt = pc_inc + rel_ofs;
  // Returns take the top entry before the pop retires it
  assign pc_next = is_ret ? stk_top : (is_relative_subroutine_call ? call_tgt : pc_inc);

  // Program counter update in Q4; a reset instruction leaves it at zero
  always_ff @(posedge REF_CLK_I) begin
    if (arch_rst) begin
      pc_reg <= RST_PC;
    end else if (do_q4 && !is_swrst) begin
      pc_reg <= pc_next;
    end else if (bus_wr && hit_pc) begin
      pc_reg <= PC_W'(lane_merge(AV_DW'(pc_reg), av_wd, av_be));
    end
  end

  // ************************************************************
  // Return stack
  // ************************************************************
  rsc_ret_stack #(
    .DEPTH(DEPTH),
    .WIDTH(PC_W),
    .PTR_W(STK_PTR_W)
  ) u_stack (
    .clk_i(REF_CLK_I),
    .rst_i(arch_rst),
    .ce_i(CE_I),
    .push_i(do_push),
    .pop_i(do_pop),
    .data_i(pc_inc),
    .top_o(stk_top),
    .depth_o(stk_depth),
    .full_o(stk_full),
    .underflow_o(stk_unf)
  );

  // ************************************************************
  // Working registers and shadows
  // ************************************************************
  wire [AV_DW-1:0] wd_acc = lane_merge(AV_DW'(acc_reg), av_wd, av_be);
  wire [AV_DW-1:0] wd_stat = lane_merge(AV_DW'(stat_reg), av_wd, av_be);
  wire [AV_DW-1:0] wd_bank = lane_merge(AV_DW'(bank_reg), av_wd, av_be);
  wire [AV_DW-1:0] wd_sacc = lane_merge(AV_DW'(sh_acc_reg), av_wd, av_be);
  wire [AV_DW-1:0] wd_sstat = lane_merge(AV_DW'(sh_stat_reg), av_wd, av_be);
  wire [AV_DW-1:0] wd_sbank = lane_merge(AV_DW'(sh_bank_reg), av_wd, av_be);
  wire [AV_DW-1:0] wd_pch = lane_merge(AV_DW'(pc_high_reg), av_wd, av_be);
  wire [AV_DW-1:0] wd_pcu = lane_merge(AV_DW'(pc_upper_reg), av_wd, av_be);
  wire restore = do_q4 && shadow_sel;

  // Accumulator: literal return, shadow restore or bus
  always_ff @(posedge REF_CLK_I) begin
    if (arch_rst) begin
      acc_reg <= RST_BYTE;
    end else if (do_q4 && is_return_with_literal) begin
      acc_reg <= op_reg[OP_LIT_MSB:0];
    end else if (restore) begin
      acc_reg <= sh_acc_reg;
    end else if (bus_wr && hit_acc) begin
      acc_reg <= wd_acc[DATA_W-1:0];
    end
  end

  // Status and bank select: shadow restore or bus
  always_ff @(posedge REF_CLK_I) begin
    if (arch_rst) begin
      stat_reg <= RST_BYTE;
      bank_reg <= RST_BYTE;
    end else if (restore) begin
      stat_reg <= sh_stat_reg;
      bank_reg <= sh_bank_reg;
    end else if (bus_wr) begin
      stat_reg <= hit_stat ? wd_stat[DATA_W-1:0] : stat_reg;
      bank_reg <= hit_bank ? wd_bank[DATA_W-1:0] : bank_reg;
    end
  end

  // Shadows are filled by software standing in for interrupt entry
  always_ff @(posedge REF_CLK_I) begin
    if (arch_rst) begin
      sh_acc_reg <= RST_BYTE;
      sh_stat_reg <= RST_BYTE;
      sh_bank_reg <= RST_BYTE;
    end else if (bus_wr) begin
      sh_acc_reg <= hit_sacc ? wd_sacc[DATA_W-1:0] : sh_acc_reg;
      sh_stat_reg <= hit_sstat ? wd_sstat[DATA_W-1:0] : sh_stat_reg;
      sh_bank_reg <= hit_sbank ? wd_sbank[DATA_W-1:0] : sh_bank_reg;
    end
  end

  // PC latches change only by bus or reset; no instruction but the software reset touches them
  always_ff @(posedge REF_CLK_I) begin
    if (arch_rst) begin
      pc_high_reg <= RST_BYTE;
      pc_upper_reg <= RST_BYTE;
    end else if (bus_wr) begin
      pc_high_reg <= hit_pch ? wd_pch[DATA_W-1:0] : pc_high_reg;
      pc_upper_reg <= hit_pcu ? wd_pcu[DATA_W-1:0] : pc_upper_reg;
    end
  end

  // Interrupt return enables high level first, then low
  always_ff @(posedge REF_CLK_I) begin
    if (arch_rst) begin
      irq_hi_reg <= 1'b0;
      irq_lo_reg <= 1'b0;
    end else if (do_q4 && is_interrupt_return) begin
      irq_hi_reg <= 1'b1;
      irq_lo_reg <= irq_lo_reg || irq_hi_reg;
    end else if (bus_wr && hit_irq) begin
      irq_hi_reg <= av_be[0] ? av_wd[IRQ_HI_BIT] : irq_hi_reg;
      irq_lo_reg <= av_be[0] ? av_wd[IRQ_LO_BIT] : irq_lo_reg;
    end
  end

  // ************************************************************
  // Read back; unmapped offsets read zero
  // ************************************************************
  wire [AV_DW-1:0] rd_stk = AV_DW'({stk_unf, stk_full, 1'b0, stk_depth});
  wire [AV_DW-1:0] rd_irq = AV_DW'({irq_lo_reg, irq_hi_reg});
  wire [AV_DW-1:0] rd_mux =
    hit_instr ? AV_DW'(op_reg) :
    hit_pc ? AV_DW'(pc_reg) :
    hit_acc ? AV_DW'(acc_reg) :
    hit_stat ? AV_DW'(stat_reg) :
    hit_bank ? AV_DW'(bank_reg) :
    hit_sacc ? AV_DW'(sh_acc_reg) :
    hit_sstat ? AV_DW'(sh_stat_reg) :
    hit_sbank ? AV_DW'(sh_bank_reg) :
    hit_irq ? rd_irq :
    hit_pch ? AV_DW'(pc_high_reg) :
    hit_pcu ? AV_DW'(pc_upper_reg) :
    hit_stop ? AV_DW'(stk_top) :
    hit_sst ? rd_stk : '0;

  // Sampled until the answer so read data stay still while shown
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      rdata_reg <= '0;
    end else if (CE_I && state_reg != ST_DONE) begin
      rdata_reg <= rd_mux;
    end
  end
  assign AVS_READDATA_O = rdata_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence s_q4_first;
    run_ce && phase_reg == PH_Q4;
  endsequence

  sequence s_ret_q4;
    s_q4_first ##0 is_ret;
  endsequence

  a_push_value: assert property (do_push && !stk_full && stk_depth != STK_PTR_W'(DEPTH)
    |=> stk_top == $past(pc_inc) && stk_depth == $past(stk_depth) + 1'b1)
    else $error("push did not stack pc plus two");

  a_discard_depth: assert property (run_ce && pop_q3 && stk_depth != '0
    |=> stk_depth == $past(stk_depth) - 1'b1 && pc_reg == $past(pc_reg))
    else $error("discard did not drop one entry");

  a_push_phase: assert property (do_push |-> phase_reg == PH_Q2 && !cyc_reg)
    else $error("stack push outside phase two");

  a_call_target: assert property (s_q4_first ##0 is_relative_subroutine_call
    |=> pc_reg == $past(pc_reg) + PC_STEP + $past(rel_ofs))
    else $error("relative call target wrong");

  a_ret_pc_load: assert property (s_ret_q4 |=> pc_reg == $past(stk_top))
    else $error("return did not load pc from stack");

  a_irq_enable_set: assert property (s_q4_first ##0 is_interrupt_return
    |=> irq_hi_reg && (irq_lo_reg || !$past(irq_hi_reg)))
    else $error("interrupt return left enables clear");

  a_shadow_keep: assert property (s_ret_q4 ##0 !shadow_sel ##0 !is_return_with_literal
    |=> acc_reg == $past(acc_reg) && bank_reg == $past(bank_reg))
    else $error("return without s changed registers");

  a_latch_keep: assert property (s_ret_q4
    |=> pc_high_reg == $past(pc_high_reg) && pc_upper_reg == $past(pc_upper_reg))
    else $error("return changed pc latches");

  a_literal_acc: assert property (s_q4_first ##0 is_return_with_literal
    |=> acc_reg == $past(op_reg[OP_LIT_MSB:0]))
    else $error("literal return lost the literal");

  a_soft_reset: assert property (do_swrst
    |=> pc_reg == RST_PC && acc_reg == RST_BYTE && stk_depth == '0 && !irq_hi_reg)
    else $error("software reset left state behind");

  a_idle_clean: assert property (s_q4_first ##0 is_idle
    |=> pc_reg == $past(pc_inc) && acc_reg == $past(acc_reg)
        && stk_depth == $past(stk_depth))
    else $error("idle instruction changed state");

  a_two_cycle_len: assert property (s_q4_first ##0 two_cyc ##1 CE_I
    |-> cyc_reg && phase_reg == PH_Q1 && state_reg == ST_RUN)
    else $error("two-cycle opcode ended early");

endmodule : rsc_call_ret_unit

// >>> verilog/rsc_ret_stack.sv
// Return address stack with sticky overflow and underflow flags
`timescale 1ns/1ps
module rsc_ret_stack
  import rsc_pkg::*;
#(
  parameter int DEPTH = STK_DEPTH,
  parameter int WIDTH = PC_W,
  parameter int PTR_W = STK_PTR_W
)
(
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Stack operations
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [WIDTH-1:0] data_i,
  // Stack state
  output logic [WIDTH-1:0] top_o,
  output logic [PTR_W-1:0] depth_o,
  output logic full_o,
  output logic underflow_o
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] ptr_reg;
  logic full_reg;
  logic unf_reg;

  // Occupancy decode
  wire can_push = ptr_reg != PTR_W'(DEPTH);
  wire can_pop = ptr_reg != '0;
  wire [PTR_W-1:0] top_idx = ptr_reg - 1'b1;

  // Entries carry no reset; the pointer alone says which are valid
  always_ff @(posedge clk_i) begin
    if (ce_i && push_i && can_push) begin
      mem[ptr_reg] <= data_i;
    end
  end

  // Pointer; a push into a full stack is dropped and flagged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_reg <= '0;
      full_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else if (ce_i && push_i) begin
      if (can_push) begin
        ptr_reg <= ptr_reg + 1'b1;
      end else begin
        full_reg <= 1'b1;
      end
    end else if (ce_i && pop_i) begin
      if (can_pop) begin
        ptr_reg <= top_idx;
      end else begin
        unf_reg <= 1'b1;
      end
    end
  end

  // An empty stack shows zero on top
  assign top_o = can_pop ? mem[top_idx] : '0;
  assign depth_o = ptr_reg;
  assign full_o = full_reg;
  assign underflow_o = unf_reg;

endmodule : rsc_ret_stack
